// ---- include/slrc_defines.vh ----
// constants for the synthesizer loop reset control block
`ifndef SLRC_DEFINES_VH
`define SLRC_DEFINES_VH

// ----------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------
`define SLRC_WORD_W 24
`define SLRC_CNT_W 5
`define SLRC_CTRL_MSB 3
`define SLRC_CTRL_LSB 0
`define SLRC_CTRL_CSR 4'b1101
`define SLRC_CTRL_RST 4'b1111

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SLRC_CSR_MSB 23
`define SLRC_CSR_LSB 22
`define SLRC_MAIN_PUMP_FLOAT_BIT 4
`define SLRC_MAIN_CLEAR_BIT 5
`define SLRC_AUX_CLEAR_BIT 6
`define SLRC_AUX_PUMP_FLOAT_BIT 7
`define SLRC_LD_QUARTER_BIT 8

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define SLRC_CSR_RESET 2'h0
`define SLRC_BIT_RESET 1'b0
`define SLRC_LD_DIV 3'h4
`define SLRC_DIV_W 4
`define SLRC_FACTOR_HALF 4'h1
`define SLRC_FACTOR_QUARTER 4'h3
`define SLRC_FACTOR_SIXTEENTH 4'hF

`endif

// ---- rtl/slrc_serial_rx.v ----
// three-line serial receiver, oversampled by the block clock
`timescale 1ns/1ps
`include "slrc_defines.vh"

module slrc_serial_rx (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire ser_clk_i,
   input wire ser_data_i,
   input wire ser_latch_i,
   output reg [`SLRC_WORD_W-1:0] word_o,
   output reg word_valid_o
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   reg [2:0] clk_meta_reg;
   reg [1:0] data_meta_reg;
   reg [2:0] latch_meta_reg;
   reg [`SLRC_WORD_W-1:0] shift_reg;
   reg [`SLRC_CNT_W-1:0] count_reg;
   wire clk_rise;
   wire latch_rise;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_meta_reg <= 3'h0;
         data_meta_reg <= 2'h0;
         latch_meta_reg <= 3'h0;
      end else begin
         clk_meta_reg <= {clk_meta_reg[1:0], ser_clk_i};
         data_meta_reg <= {data_meta_reg[0], ser_data_i};
         latch_meta_reg <= {latch_meta_reg[1:0], ser_latch_i};
      end
   end

   // edges are found between the second and third stages only
   assign clk_rise = clk_meta_reg[1] & ~clk_meta_reg[2];
   assign latch_rise = latch_meta_reg[1] & ~latch_meta_reg[2];

   // ----------------------------------------------------------------
   // shift and latch
   // ----------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_reg <= 24'h00_0000;
         count_reg <= 5'h00;
         word_o <= 24'h00_0000;
         word_valid_o <= 1'b0;
      end else begin
         word_valid_o <= 1'b0;
         if (latch_rise) begin
            // only a complete word is handed on; see [R2] see [R11]
            if (count_reg >= `SLRC_WORD_W) begin
               word_o <= shift_reg;
               word_valid_o <= 1'b1;
            end
            count_reg <= 5'h00;
         end else if (clk_rise) begin
            shift_reg <= {shift_reg[`SLRC_WORD_W-2:0], data_meta_reg[1]};
            if (count_reg < `SLRC_WORD_W)
               count_reg <= count_reg + 5'h01;
         end
      end
   end

endmodule

// ---- rtl/slrc_top.v ----
// loop reset control: word decode, counter clears, pump float, lock detect rate
// Notes on behaviour
// [R1] The two-bit cycle slip reduction code picks a sample rate factor of 1, 1/2, 1/4 or 1/16.
// [R2] Words are 24 bits, 20 data bits over a 4-bit control code, all ones marking the reset word.
// [R3] The quarter-rate bit divides main-loop comparison events to lock detect by 4, auxiliary untouched.
// [R4] The host should set the quarter-rate bit when lock detect runs above a 20 MHz comparison rate.
// [R5] The auxiliary clear bit holds auxiliary N and R counters in reset and floats its pump.
// [R6] The main clear bit holds main N and R counters in reset and floats its pump.
// [R7] Leaving power-down, by software or by the enable pin, applies a counter reset.
// [R8] The main pump-float bit floats the main pump while its counters keep running.
// [R9] The auxiliary pump-float bit floats the auxiliary pump while its counters keep running.
// [R10] The host should keep both clear bits at zero in normal operation.
// [R11] Settings change only after a complete 24-bit word with the all-ones or the 1101 control code is latched.
`timescale 1ns/1ps
`include "slrc_defines.vh"

module slrc_top (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire ser_clk_i,
   input wire ser_data_i,
   input wire ser_latch_i,
   input wire chip_enable_i,
   input wire soft_power_down_i,
   input wire main_cmp_pulse_i,
   input wire aux_cmp_pulse_i,
   output reg [1:0] cycle_slip_reduction_o,
   output reg [3:0] csr_divide_o,
   output reg csr_sample_o,
   output reg main_ld_cmp_o,
   output reg aux_ld_cmp_o,
   output reg main_counter_reset_o,
   output reg aux_counter_reset_o,
   output reg main_pump_hiz_o,
   output reg aux_pump_hiz_o,
   output reg lock_detect_quarter_rate_o,
   output reg powered_up_o
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // last count of the sample divider for a reduction code
   function [`SLRC_DIV_W-1:0] csr_last;
      input [1:0] code;
      begin
         case (code)
            2'h1: csr_last = `SLRC_FACTOR_HALF;
            2'h2: csr_last = `SLRC_FACTOR_QUARTER;
            2'h3: csr_last = `SLRC_FACTOR_SIXTEENTH;
            default: csr_last = 4'h0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // serial receiver
   // ----------------------------------------------------------------
   wire [`SLRC_WORD_W-1:0] rx_word;
   wire rx_valid;

   slrc_serial_rx u_rx (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .ser_clk_i(ser_clk_i),
      .ser_data_i(ser_data_i),
      .ser_latch_i(ser_latch_i),
      .word_o(rx_word),
      .word_valid_o(rx_valid)
   );

   wire [3:0] rx_ctrl;
   wire csr_word;
   wire rst_word;

   assign rx_ctrl = rx_word[`SLRC_CTRL_MSB:`SLRC_CTRL_LSB];
   assign csr_word = rx_valid & (rx_ctrl == `SLRC_CTRL_CSR);
   assign rst_word = rx_valid & (rx_ctrl == `SLRC_CTRL_RST); // see [R2]

   // ----------------------------------------------------------------
   // settings
   // ----------------------------------------------------------------
   reg [1:0] csr_code_reg;
   reg main_clear_reg;
   reg aux_clear_reg;
   reg main_float_reg;
   reg aux_float_reg;
   reg quarter_reg;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         csr_code_reg <= `SLRC_CSR_RESET;
         main_clear_reg <= `SLRC_BIT_RESET;
         aux_clear_reg <= `SLRC_BIT_RESET;
         main_float_reg <= `SLRC_BIT_RESET;
         aux_float_reg <= `SLRC_BIT_RESET;
         quarter_reg <= `SLRC_BIT_RESET;
      end else begin
         if (csr_word)
            csr_code_reg <= rx_word[`SLRC_CSR_MSB:`SLRC_CSR_LSB]; // see [R1]
         if (rst_word) begin // see [R11]
            main_clear_reg <= rx_word[`SLRC_MAIN_CLEAR_BIT];
            aux_clear_reg <= rx_word[`SLRC_AUX_CLEAR_BIT];
            main_float_reg <= rx_word[`SLRC_MAIN_PUMP_FLOAT_BIT];
            aux_float_reg <= rx_word[`SLRC_AUX_PUMP_FLOAT_BIT];
            quarter_reg <= rx_word[`SLRC_LD_QUARTER_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // power state and power-up reset
   // ----------------------------------------------------------------
   reg [1:0] ce_sync_reg;
   reg powered_reg;
   wire powered_now;
   wire power_up_event;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         ce_sync_reg <= 2'h0;
      else
         ce_sync_reg <= {ce_sync_reg[0], chip_enable_i};
   end

   assign powered_now = ce_sync_reg[1] & ~soft_power_down_i;
   assign power_up_event = powered_now & ~powered_reg;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         powered_reg <= 1'b0;
      else
         powered_reg <= powered_now;
   end

   // ----------------------------------------------------------------
   // counter reset and pump float outputs
   // ----------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_counter_reset_o <= 1'b1;
         aux_counter_reset_o <= 1'b1;
         main_pump_hiz_o <= 1'b1;
         aux_pump_hiz_o <= 1'b1;
         powered_up_o <= 1'b0;
         lock_detect_quarter_rate_o <= 1'b0;
         cycle_slip_reduction_o <= 2'h0;
      end else begin
         // power-down holds counters; the power-up cycle resets them once more
         main_counter_reset_o <= main_clear_reg | ~powered_now | power_up_event; // see [R6] see [R7]
         aux_counter_reset_o <= aux_clear_reg | ~powered_now | power_up_event; // see [R5] see [R7]
         // a counter reset always floats the pump, the power-up one included
         main_pump_hiz_o <= main_clear_reg | main_float_reg | ~powered_now | power_up_event; // see [R6] see [R8] see [R7]
         aux_pump_hiz_o <= aux_clear_reg | aux_float_reg | ~powered_now | power_up_event; // see [R5] see [R9] see [R7]
         powered_up_o <= powered_now;
         lock_detect_quarter_rate_o <= quarter_reg;
         cycle_slip_reduction_o <= csr_code_reg;
      end
   end

   // ----------------------------------------------------------------
   // lock detect comparison rate
   // ----------------------------------------------------------------
   reg [1:0] ld_div_reg;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ld_div_reg <= 2'h0;
         main_ld_cmp_o <= 1'b0;
         aux_ld_cmp_o <= 1'b0;
      end else begin
         aux_ld_cmp_o <= aux_cmp_pulse_i; // see [R3]
         if (!quarter_reg) begin
            ld_div_reg <= 2'h0;
            main_ld_cmp_o <= main_cmp_pulse_i;
         end else if (main_cmp_pulse_i) begin
            // one event in four passes on
            ld_div_reg <= ld_div_reg + 2'h1; // see [R3]
            main_ld_cmp_o <= (ld_div_reg == 2'h3);
         end else begin
            main_ld_cmp_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // cycle slip reduction sample rate
   // ----------------------------------------------------------------
   reg [`SLRC_DIV_W-1:0] csr_cnt_reg;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         csr_cnt_reg <= 4'h0;
         csr_sample_o <= 1'b0;
         csr_divide_o <= 4'h0;
      end else begin
         csr_divide_o <= csr_last(csr_code_reg); // see [R1]
         if (main_counter_reset_o) begin
            csr_cnt_reg <= 4'h0;
            csr_sample_o <= 1'b0;
         end else if (main_cmp_pulse_i) begin
            if (csr_cnt_reg >= csr_last(csr_code_reg)) begin
               csr_cnt_reg <= 4'h0;
               csr_sample_o <= 1'b1; // see [R1]
            end else begin
               csr_cnt_reg <= csr_cnt_reg + 4'h1;
               csr_sample_o <= 1'b0;
            end
         end else begin
            csr_sample_o <= 1'b0;
         end
      end
   end

endmodule

// ---- tb/slrc_chk.sv ----
// port checker for the loop reset control block
`timescale 1ns/1ps
module slrc_chk (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire ser_latch_i,
   input wire main_cmp_pulse_i,
   input wire aux_cmp_pulse_i,
   input wire [1:0] cycle_slip_reduction_o,
   input wire [3:0] csr_divide_o,
   input wire csr_sample_o,
   input wire main_ld_cmp_o,
   input wire aux_ld_cmp_o,
   input wire main_counter_reset_o,
   input wire aux_counter_reset_o,
   input wire main_pump_hiz_o,
   input wire aux_pump_hiz_o,
   input wire lock_detect_quarter_rate_o,
   input wire powered_up_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_main_evt;
      main_cmp_pulse_i && !lock_detect_quarter_rate_o;
   endsequence
   sequence s_down;
      !powered_up_o ##1 !powered_up_o;
   endsequence
   function automatic [3:0] div_of(input [1:0] c);
      div_of = (c == 2'h3) ? 4'hF : {2'h0, c == 2'h2, c != 2'h0};
   endfunction
   chk_aux_cmp_pass: assert property (aux_cmp_pulse_i |=> aux_ld_cmp_o)
      else $error("aux event lost");
   chk_main_full_rate: assert property (s_main_evt |=> main_ld_cmp_o)
      else $error("main event lost");
   chk_ld_has_cause: assert property (main_ld_cmp_o |-> $past(main_cmp_pulse_i))
      else $error("lock detect pulse without event");
   chk_sample_cause: assert property (csr_sample_o |-> $past(main_cmp_pulse_i))
      else $error("sample without event");
   chk_csr_factor: assert property ($stable(cycle_slip_reduction_o) [*2] |->
      csr_divide_o == div_of(cycle_slip_reduction_o))
      else $error("divider count wrong");
   chk_main_clear_hiz: assert property (main_counter_reset_o |-> main_pump_hiz_o)
      else $error("main pump driven in reset");
   chk_aux_clear_hiz: assert property (aux_counter_reset_o |-> aux_pump_hiz_o)
      else $error("aux pump driven in reset");
   chk_down_holds: assert property (s_down |-> main_counter_reset_o && aux_counter_reset_o)
      else $error("counters run while down");
   chk_powerup_clear: assert property ($rose(powered_up_o) |->
      ##[0:1] (main_counter_reset_o && aux_counter_reset_o))
      else $error("no counter reset at power up");
   chk_word_gates: assert property ($changed({cycle_slip_reduction_o, lock_detect_quarter_rate_o})
      |-> ser_latch_i)
      else $error("setting changed without latch");
endmodule
bind slrc_top slrc_chk u_chk (.*);

// ---- tb/slrc_host.sv ----
// host model writing serial programming words
`timescale 1ns/1ps
module slrc_host (
   input wire clk_i,
   output reg sclk_o = 1'b0,
   output reg sdata_o = 1'b0,
   output reg slatch_o = 1'b0
);
   // clock stands low between words; data line shows the inverse once released
   task send(input [23:0] w, input integer n);
      integer i;
      begin
         for (i = n - 1; i >= 0; i = i - 1) begin
            sdata_o <= w[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
         end
         sdata_o <= ~w[0];
         repeat (4) @(posedge clk_i);
         slatch_o <= 1'b1;
         repeat (8) @(posedge clk_i);
         slatch_o <= 1'b0;
      end
   endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the loop reset control block
`timescale 1ns/1ps
module testbench;
   reg ref_clk_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg chip_enable_i = 1'b0;
   reg soft_power_down_i = 1'b0;
   reg main_cmp_pulse_i = 1'b0;
   reg aux_cmp_pulse_i = 1'b0;
   wire ser_clk_i, ser_data_i, ser_latch_i, csr_sample_o, main_ld_cmp_o, aux_ld_cmp_o;
   wire main_counter_reset_o, aux_counter_reset_o, main_pump_hiz_o, aux_pump_hiz_o;
   wire lock_detect_quarter_rate_o, powered_up_o;
   wire [1:0] cycle_slip_reduction_o;
   wire [3:0] csr_divide_o;
   integer n_fail = 0, checks = 0, cyc = 0, n_main = 0, n_aux = 0, n_csr = 0, b0, b1, b2;
   initial forever #10 ref_clk_i = ~ref_clk_i;
   slrc_top DUT (.*);
   slrc_host host (.clk_i(ref_clk_i), .sclk_o(ser_clk_i), .sdata_o(ser_data_i), .slatch_o(ser_latch_i));
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      n_main <= n_main + main_ld_cmp_o;
      n_aux <= n_aux + aux_ld_cmp_o;
      n_csr <= n_csr + csr_sample_o;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         finish_test;
      end
   end
   task chk(input ok, input [8*24:1] msg);
      begin
         checks = checks + 1;
         if (!ok) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: %0s", $time, msg);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d n_fail %0d", checks, n_fail);
         if (n_fail == 0 && checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task wr(input [23:0] w, input integer n);
      begin
         host.send(w, n);
         repeat (4) @(posedge ref_clk_i);
      end
   endtask
   // back-to-back events for n cycles, counts left in b0 b1 b2
   task pulse(input m, input a, input integer n);
      begin
         b0 = n_main;
         b1 = n_aux;
         b2 = n_csr;
         main_cmp_pulse_i <= m;
         aux_cmp_pulse_i <= a;
         repeat (n) @(posedge ref_clk_i);
         main_cmp_pulse_i <= 1'b0;
         aux_cmp_pulse_i <= 1'b0;
         repeat (4) @(posedge ref_clk_i);
         b0 = n_main - b0;
         b1 = n_aux - b1;
         b2 = n_csr - b2;
      end
   endtask
   task t_csr;
      integer c;
      begin
         for (c = 0; c < 4; c = c + 1) begin
            wr({c[1:0], 18'h0_0000, 4'hD}, 24);
            chk(cycle_slip_reduction_o === c[1:0], "csr code");
            pulse(1'b1, 1'b0, 16);
            chk(b2 === (16 >> ((c == 3) ? 4 : c)) && b0 === 16, "csr rate");
         end
      end
   endtask
   task t_fields;
      integer k;
      reg [4:0] e;
      begin
         for (k = 0; k < 5; k = k + 1) begin
            wr(24'h00_000F | (24'h00_0010 << k), 24);
            e = {k == 4, k == 2 || k == 3, k == 2, k == 1, k < 2};
            chk({lock_detect_quarter_rate_o, aux_pump_hiz_o, aux_counter_reset_o, main_counter_reset_o,
               main_pump_hiz_o} === e, "field decode");
         end
         pulse(1'b1, 1'b1, 8);
         chk(b0 === 2 && b1 === 8, "quarter rate");
      end
   endtask
   task t_refuse;
      begin
         wr(24'h00_000F, 20);
         wr(24'h00_000E, 24);
         chk(lock_detect_quarter_rate_o === 1'b1, "bad word taken");
         wr(24'h00_000F, 24);
         chk(lock_detect_quarter_rate_o === 1'b0, "clear word");
      end
   endtask
   task t_soft;
      begin
         soft_power_down_i <= 1'b1;
         repeat (3) @(posedge ref_clk_i);
         chk(main_counter_reset_o === 1'b1 && aux_pump_hiz_o === 1'b1, "soft down");
         soft_power_down_i <= 1'b0;
         repeat (2) @(posedge ref_clk_i);
         chk({main_counter_reset_o, aux_counter_reset_o, main_pump_hiz_o} === 3'h7, "power-up reset");
         repeat (2) @(posedge ref_clk_i);
         chk(main_counter_reset_o === 1'b0 && aux_counter_reset_o === 1'b0, "soft up");
      end
   endtask
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      chk(main_counter_reset_o === 1'b1 && aux_pump_hiz_o === 1'b1, "down state");
      chip_enable_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      chk(powered_up_o === 1'b1 && {main_counter_reset_o, aux_counter_reset_o, main_pump_hiz_o,
         aux_pump_hiz_o} === 4'h0, "power up");
      t_csr;
      t_fields;
      t_refuse;
      t_soft;
      finish_test;
   end
endmodule
